//--- hdl/crff_pkg.sv
// package: register map, field layout, types and states of the receive fifo identifier filter
//
// Summary of operation
// - every table word is decoded with the layout held in the control register layout field.
// - table words 4..107 sit at consecutive words, word 4 at byte offset 0xe0.
// - one layout applies to the whole table; words are never decoded in mixed layouts.
// - single layout bit 31: 0 stores data frames only, 1 stores remote frames only.
// - single layout bit 30: 0 stores standard frames only, 1 stores extended frames only.
// - single layout compares bits 28:18 for standard frames, bits 28:0 for extended frames.
// - dual layout holds element 0 in bits 31,30,29:16 and element 1 in 15,14,13:0.
// - dual layout remote and extended selects filter frame types as in single layout.
// - dual layout standard element compares its top eleven bits with the standard identifier.
// - dual layout extended element compares fourteen bits with the identifier's fourteen msbs.
// - quad layout holds four 8-bit partial identifiers, bits 31:24 first, 7:0 last.
// - quad layout compares each byte with the identifier msbs, standard or extended alike.
// - a stored frame is reported with the number of the table element that matched.
package crff_pkg;

  // ------------------------------------------------------------------
  // register map
  // ------------------------------------------------------------------
  localparam logic [11:0] CRFF_CTRL_OFF      = 12'h000;
  localparam logic [11:0] CRFF_STAT_OFF      = 12'h004;
  localparam logic [11:0] CRFF_TABLE_OFF     = 12'h0e0;
  localparam int          CRFF_FIRST_INDEX   = 4;
  localparam int          CRFF_LAST_INDEX    = 107;
  localparam int          CRFF_TABLE_WORDS   = CRFF_LAST_INDEX - CRFF_FIRST_INDEX + 1;
  localparam int          CRFF_WADDR_W       = 7;
  localparam logic [6:0]  CRFF_LAST_WORD     = 7'(CRFF_TABLE_WORDS - 1);
  localparam logic [11:0] CRFF_TABLE_END     = CRFF_TABLE_OFF + 12'(4 * (CRFF_TABLE_WORDS - 1));
  localparam logic [31:0] CRFF_CTRL_RESET    = 32'h0000_0000;

  // control and status field positions
  localparam int          CRFF_LAYOUT_POS    = 8;
  localparam int          CRFF_STAT_BUSY_POS = 12;
  localparam int          CRFF_STAT_REJ_POS  = 16;
  localparam int          CRFF_STAT_STO_POS  = 24;

  // ------------------------------------------------------------------
  // table word fields
  // ------------------------------------------------------------------
  localparam int          CRFF_A_REMOTE_POS  = 31;
  localparam int          CRFF_A_EXT_POS     = 30;
  localparam int          CRFF_A_ID_MSB      = 28;
  localparam int          CRFF_B0_REMOTE_POS = 31;
  localparam int          CRFF_B0_EXT_POS    = 30;
  localparam int          CRFF_B0_ID_MSB     = 29;
  localparam int          CRFF_B1_REMOTE_POS = 15;
  localparam int          CRFF_B1_EXT_POS    = 14;
  localparam int          CRFF_B1_ID_MSB     = 13;
  localparam int          CRFF_B_ID_W        = 14;
  localparam int          CRFF_C_ID_W        = 8;

  // received identifier: standard id in bits 28:18
  localparam int          CRFF_STD_MSB       = 28;
  localparam int          CRFF_STD_LSB       = 18;
  localparam int          CRFF_STD_W         = 11;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    CRFF_LAYOUT_SINGLE = 2'b00,
    CRFF_LAYOUT_DUAL   = 2'b01,
    CRFF_LAYOUT_QUAD   = 2'b10,
    CRFF_LAYOUT_RSVD   = 2'b11
  } crff_layout_e;

  typedef enum logic [1:0] {
    CRFF_BUS_ISSUE   = 2'b00,
    CRFF_BUS_CAPTURE = 2'b01,
    CRFF_BUS_REPLY   = 2'b10
  } crff_bus_e;

  typedef enum logic [1:0] {
    CRFF_ST_IDLE = 2'b00,
    CRFF_ST_SCAN = 2'b01
  } crff_state_e;

  typedef struct packed {
    logic [28:0] ident;
    logic        extended;
    logic        remote;
  } crff_frame_s;

  typedef struct packed {
    logic       stored;
    logic       rejected;
    logic [8:0] element;
  } crff_result_s;

endpackage

//--- hdl/crff_table_mem.sv
// filter table storage: one port, registered read data
`timescale 1ns/1ps
module crff_table_mem
  import crff_pkg::*;
(
  input  wire logic                    mclk_i,
  input  wire logic                    we_i,
  input  wire logic                    re_i,
  input  wire logic [CRFF_WADDR_W-1:0] addr_i,
  input  wire logic [31:0]             wdata_i,
  output logic      [31:0]             rdata_o
);

  logic [31:0] mem [CRFF_TABLE_WORDS];

  // read data holds until the next read, so the scanner may look one cycle later
  always_ff @(posedge mclk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
    if (re_i) begin
      rdata_o <= mem[addr_i];
    end
  end

endmodule

//--- hdl/crff_word_match.sv
// compares one table word, in the selected layout, with a received frame
`timescale 1ns/1ps
module crff_word_match
  import crff_pkg::*;
(
  input  wire logic [31:0] word_i,
  input  crff_layout_e     layout_i,
  input  crff_frame_s      frame_i,
  output logic      [3:0]  hit_o
);

  // ------------------------------------------------------------------
  // element compare functions
  // ------------------------------------------------------------------
  function automatic logic dual_hit(input logic rsel, input logic esel,
                                    input logic [CRFF_B_ID_W-1:0] idf, input crff_frame_s f);
    logic id_ok;
    id_ok = esel ? (idf == f.ident[CRFF_STD_MSB -: CRFF_B_ID_W])
                 : (idf[CRFF_B_ID_W-1 -: CRFF_STD_W] == f.ident[CRFF_STD_MSB -: CRFF_STD_W]);
    return id_ok && (rsel == f.remote) && (esel == f.extended);
  endfunction

  function automatic logic quad_hit(input logic [CRFF_C_ID_W-1:0] idf, input crff_frame_s f);
    return idf == f.ident[CRFF_STD_MSB -: CRFF_C_ID_W];
  endfunction

  // ------------------------------------------------------------------
  // per-layout hits
  // ------------------------------------------------------------------
  wire logic a_ext  = word_i[CRFF_A_EXT_POS];
  wire logic a_type = (word_i[CRFF_A_REMOTE_POS] == frame_i.remote) &&
                      (a_ext == frame_i.extended);
  // bit 29 is never compared
  wire logic a_id   = a_ext ? (word_i[CRFF_A_ID_MSB:0] == frame_i.ident)
                            : (word_i[CRFF_A_ID_MSB -: CRFF_STD_W] == frame_i.ident[CRFF_STD_MSB -: CRFF_STD_W]);
  wire logic a_hit  = a_type && a_id;

  wire logic b0_hit = dual_hit(word_i[CRFF_B0_REMOTE_POS], word_i[CRFF_B0_EXT_POS],
                               word_i[CRFF_B0_ID_MSB -: CRFF_B_ID_W], frame_i);
  wire logic b1_hit = dual_hit(word_i[CRFF_B1_REMOTE_POS], word_i[CRFF_B1_EXT_POS],
                               word_i[CRFF_B1_ID_MSB -: CRFF_B_ID_W], frame_i);

  // element 0 sits in the top byte
  wire logic [3:0] c_hit = {quad_hit(word_i[7:0], frame_i), quad_hit(word_i[15:8], frame_i),
                            quad_hit(word_i[23:16], frame_i), quad_hit(word_i[31:24], frame_i)};

  // one layout for every word
  assign hit_o = (layout_i == CRFF_LAYOUT_SINGLE) ? {3'b000, a_hit} :
                 (layout_i == CRFF_LAYOUT_DUAL)   ? {2'b00, b1_hit, b0_hit} :
                 (layout_i == CRFF_LAYOUT_QUAD)   ? c_hit : 4'b0000;

endmodule

//--- hdl/crff_filter.sv
// receive fifo identifier filter: apb register file, table scan and match report
`timescale 1ns/1ps
module crff_filter
  import crff_pkg::*;
(
  input  wire logic         mclk_i,
  input  wire logic         rst_i,
  input  wire logic [11:0]  paddr_i,
  input  wire logic         psel_i,
  input  wire logic         penable_i,
  input  wire logic         pwrite_i,
  input  wire logic [31:0]  pwdata_i,
  output logic      [31:0]  prdata_o,
  output logic              pready_o,
  output logic              pslverr_o,
  input  wire logic         rx_valid_i,
  input  crff_frame_s       rx_frame_i,
  output logic              rx_ready_o,
  output crff_result_s      result_o
);

  // ------------------------------------------------------------------
  // functions
  // ------------------------------------------------------------------
  function automatic logic [1:0] first_hit(input logic [3:0] h);
    return h[0] ? 2'd0 : h[1] ? 2'd1 : h[2] ? 2'd2 : 2'd3;
  endfunction

  // element number: words count from zero, lower sub-element wins
  function automatic logic [8:0] element_number(input crff_layout_e l, input logic [6:0] w,
                                                input logic [3:0] h);
    logic [8:0] base;
    base = {2'b00, w};
    case (l)
      CRFF_LAYOUT_DUAL: element_number = 9'((base << 1) + {7'd0, first_hit(h)});
      CRFF_LAYOUT_QUAD: element_number = 9'((base << 2) + {7'd0, first_hit(h)});
      default:          element_number = base;
    endcase
  endfunction

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  crff_bus_e    bus_phase;
  crff_layout_e layout;
  crff_state_e  state;
  crff_frame_s  frame_q;
  crff_layout_e layout_q;
  logic [6:0]   issue_word;
  logic         issue_done;
  logic         eval_vld;
  logic [6:0]   eval_word;
  logic [8:0]   last_element;
  logic [7:0]   stored_count;
  logic [7:0]   rejected_count;
  logic [31:0]  mem_rdata;
  logic [3:0]   hits;

  // ------------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------------
  wire logic [11:0] tbl_off   = paddr_i - CRFF_TABLE_OFF;
  wire logic [6:0]  tbl_word  = tbl_off[8:2];
  wire logic        hit_ctrl  = (paddr_i == CRFF_CTRL_OFF);
  wire logic        hit_stat  = (paddr_i == CRFF_STAT_OFF);
  wire logic        hit_table = (paddr_i >= CRFF_TABLE_OFF) && (paddr_i <= CRFF_TABLE_END) &&
                                (paddr_i[1:0] == 2'b00);
  wire logic        mapped    = hit_ctrl || hit_stat || hit_table;
  wire logic        access    = psel_i && penable_i;

  // two wait states for every access keep reads of the table and the registers alike
  assign pready_o  = access && (bus_phase == CRFF_BUS_REPLY);
  assign pslverr_o = pready_o && !mapped;

  wire logic bus_wr     = pready_o && pwrite_i;
  wire logic bus_mem_rd = access && (bus_phase == CRFF_BUS_ISSUE) && !pwrite_i && hit_table;
  wire logic bus_mem_wr = bus_wr && hit_table;
  wire logic ctrl_wr    = bus_wr && hit_ctrl;

  // ------------------------------------------------------------------
  // scan control
  // ------------------------------------------------------------------
  // the scanner yields the table port whenever the bus selects the block
  wire logic accept   = (state == CRFF_ST_IDLE) && rx_valid_i;
  wire logic scan_rd  = (state == CRFF_ST_SCAN) && !psel_i && !issue_done;
  wire logic mem_re   = bus_mem_rd || scan_rd;
  wire logic [6:0] mem_addr = psel_i ? tbl_word : issue_word;

  wire logic eval_now  = (state == CRFF_ST_SCAN) && eval_vld;
  wire logic eval_hit  = eval_now && (hits != 4'b0000);
  // a frame that matched no element is dropped
  wire logic eval_miss = eval_now && (hits == 4'b0000) && (eval_word == CRFF_LAST_WORD);
  wire logic [8:0] eval_element = element_number(layout_q, eval_word, hits);

  assign rx_ready_o = (state == CRFF_ST_IDLE);

  wire crff_state_e next_state = accept ? CRFF_ST_SCAN :
                                 (eval_hit || eval_miss) ? CRFF_ST_IDLE : state;

  wire logic [31:0] ctrl_word = 32'(layout) << CRFF_LAYOUT_POS;
  wire logic [31:0] stat_word = (32'(stored_count) << CRFF_STAT_STO_POS) |
                                (32'(rejected_count) << CRFF_STAT_REJ_POS) |
                                (32'(state == CRFF_ST_SCAN) << CRFF_STAT_BUSY_POS) |
                                32'(last_element);
  wire logic [31:0] next_rdata = pwrite_i ? 32'h0000_0000 :
                                 hit_ctrl ? ctrl_word :
                                 hit_stat ? stat_word :
                                 hit_table ? mem_rdata : 32'h0000_0000;

  // ------------------------------------------------------------------
  // instances
  // ------------------------------------------------------------------
  crff_table_mem u_mem (
    .mclk_i  (mclk_i),
    .we_i    (bus_mem_wr),
    .re_i    (mem_re),
    .addr_i  (mem_addr),
    .wdata_i (pwdata_i),
    .rdata_o (mem_rdata)
  );

  crff_word_match u_match (
    .word_i   (mem_rdata),
    .layout_i (layout_q),
    .frame_i  (frame_q),
    .hit_o    (hits)
  );

  // ------------------------------------------------------------------
  // bus side registers
  // ------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      bus_phase <= CRFF_BUS_ISSUE;
      prdata_o  <= 32'h0000_0000;
      layout    <= crff_layout_e'(CRFF_CTRL_RESET[CRFF_LAYOUT_POS +: 2]);
    end else begin
      case (bus_phase)
        CRFF_BUS_ISSUE:   bus_phase <= access ? CRFF_BUS_CAPTURE : CRFF_BUS_ISSUE;
        CRFF_BUS_CAPTURE: bus_phase <= CRFF_BUS_REPLY;
        default:          bus_phase <= CRFF_BUS_ISSUE;
      endcase
      if (bus_phase == CRFF_BUS_CAPTURE) begin
        prdata_o <= next_rdata;
      end
      if (ctrl_wr) begin
        layout <= crff_layout_e'(pwdata_i[CRFF_LAYOUT_POS +: 2]);
      end
    end
  end

  // ------------------------------------------------------------------
  // scanner registers
  // ------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state      <= CRFF_ST_IDLE;
      frame_q    <= '0;
      layout_q   <= CRFF_LAYOUT_SINGLE;
      issue_word <= 7'h00;
      issue_done <= 1'b0;
      eval_vld   <= 1'b0;
      eval_word  <= 7'h00;
    end else begin
      state     <= next_state;
      eval_vld  <= scan_rd;
      eval_word <= issue_word;
      if (accept) begin
        frame_q    <= rx_frame_i;
        // latched so a layout change cannot split one scan over two layouts
        layout_q   <= layout;
        issue_word <= 7'h00;
        issue_done <= 1'b0;
      end else if (scan_rd) begin
        issue_done <= (issue_word == CRFF_LAST_WORD);
        issue_word <= (issue_word == CRFF_LAST_WORD) ? issue_word : 7'(issue_word + 7'h01);
      end
    end
  end

  // ------------------------------------------------------------------
  // outcome
  // ------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      result_o       <= '0;
      last_element   <= 9'h000;
      stored_count   <= 8'h00;
      rejected_count <= 8'h00;
    end else begin
      result_o.stored   <= eval_hit;
      result_o.rejected <= eval_miss;
      if (eval_hit) begin
        result_o.element <= eval_element;
        last_element     <= eval_element;
        stored_count     <= 8'(stored_count + 8'h01);
      end
      if (eval_miss) begin
        rejected_count <= 8'(rejected_count + 8'h01);
      end
    end
  end

endmodule

//--- sim/crff_filter_checker.sv
// checker: apb answer, frame take and result relations at the filter top ports
`timescale 1ns/1ps
module crff_filter_checker
  import crff_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [31:0] prdata_o,
  input  wire logic        pready_o,
  input  wire logic        pslverr_o,
  input  wire logic        rx_valid_i,
  input  crff_frame_s      rx_frame_i,
  input  wire logic        rx_ready_o,
  input  crff_result_s     result_o
);
  logic [1:0] lay;
  wire        take = rx_valid_i && rx_ready_o;
  wire        done = result_o.stored || result_o.rejected;
  // layout as software last wrote it; scans are never overlapped with a layout change here
  always_ff @(posedge mclk_i) begin
    if (rst_i) lay <= 2'b00;
    else if (psel_i && penable_i && pready_o && pwrite_i && paddr_i == CRFF_CTRL_OFF) lay <= pwdata_i[9:8];
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  property p_busy; take |=> !rx_ready_o; endproperty
  a_busy: assert property (p_busy) else $error("frame taken while scanning");
  property p_done; take |-> ##[3:1000] done; endproperty
  a_done: assert property (p_done) else $error("no result for frame");
  property p_excl; result_o.stored |-> !result_o.rejected; endproperty
  a_excl: assert property (p_excl) else $error("stored and rejected together");
  property p_pulse; done |=> !done; endproperty
  a_pulse: assert property (p_pulse) else $error("result longer than one cycle");
  property p_back; done |-> rx_ready_o; endproperty
  a_back: assert property (p_back) else $error("ready not back with result");
  property p_hold; !result_o.stored |-> $stable(result_o.element); endproperty
  a_hold: assert property (p_hold) else $error("element changed without store");
  property p_single; result_o.stored && lay == CRFF_LAYOUT_SINGLE |-> result_o.element <= 9'd103; endproperty
  a_single: assert property (p_single) else $error("single element out of range");
  property p_dual; result_o.stored && lay == CRFF_LAYOUT_DUAL |-> result_o.element <= 9'd207; endproperty
  a_dual: assert property (p_dual) else $error("dual element out of range");
  property p_rsvd; lay == CRFF_LAYOUT_RSVD |-> !result_o.stored; endproperty
  a_rsvd: assert property (p_rsvd) else $error("store in reserved layout");
  property p_past_end; pready_o && paddr_i > CRFF_TABLE_END |-> pslverr_o; endproperty
  a_past_end: assert property (p_past_end) else $error("no error past table");
  property p_in_tbl;
    pready_o && paddr_i >= CRFF_TABLE_OFF && paddr_i <= CRFF_TABLE_END && paddr_i[1:0] == 2'b00 |-> !pslverr_o;
  endproperty
  a_in_tbl: assert property (p_in_tbl) else $error("error on table word");
  // two wait states on every access, ready only in the third access cycle
  property p_wait;
    psel_i && penable_i && $past(psel_i && !penable_i) |-> !pready_o ##1 !pready_o ##1 pready_o;
  endproperty
  a_wait: assert property (p_wait) else $error("ready not in third access cycle");
  c_stored: cover property (result_o.stored);
  c_rejected: cover property (result_o.rejected);
  c_err: cover property (pready_o && pslverr_o);
endmodule

bind crff_filter crff_filter_checker u_chk (.mclk_i(mclk_i), .rst_i(rst_i), .paddr_i(paddr_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .rx_valid_i(rx_valid_i), .rx_frame_i(rx_frame_i),
  .rx_ready_o(rx_ready_o), .result_o(result_o));

//--- sim/crff_engine_model.sv
// model of the protocol engine offering received frame identifiers
`timescale 1ns/1ps
module crff_engine_model
  import crff_pkg::*;
(
  input  wire logic  mclk_i,
  input  wire logic  rst_i,
  input  wire logic  start_i,
  input  crff_frame_s frame_i,
  input  wire logic  rx_ready_i,
  output logic       rx_valid_o,
  output crff_frame_s rx_frame_o
);
  // a taken frame leaves its inverse on the lines so a stale id cannot pass by chance
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rx_valid_o <= 1'b0;
      rx_frame_o <= '0;
    end else if (rx_valid_o && rx_ready_i) begin
      rx_valid_o <= 1'b0;
      rx_frame_o <= ~rx_frame_o;
    end else if (start_i && !rx_valid_o) begin
      rx_valid_o <= 1'b1;
      rx_frame_o <= frame_i;
    end
  end
endmodule

//--- sim/tb_crff_filter.sv
// testbench: register access, table fill per layout, frames checked against a bench model
`timescale 1ns/1ps
module tb_crff_filter;
  import crff_pkg::*;
  logic        mclk_i = 0, rst_i = 1, psel = 0, pen = 0, pwr = 0, start = 0;
  logic        valid, pready, perr, rdy;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [31:0] tbl [CRFF_TABLE_WORDS];
  crff_frame_s fr = '0, rxf;
  crff_result_s res;
  int          error_cnt = 0, cmp_count = 0, cyc = 0, nsto = 0, nrej = 0, lastel = 0;

  initial forever #50 mclk_i = ~mclk_i;
  crff_filter uut (.mclk_i(mclk_i), .rst_i(rst_i), .paddr_i(paddr), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr),
    .rx_valid_i(valid), .rx_frame_i(rxf), .rx_ready_o(rdy), .result_o(res));
  crff_engine_model eng (.mclk_i(mclk_i), .rst_i(rst_i), .start_i(start), .frame_i(fr),
    .rx_ready_i(rdy), .rx_valid_o(valid), .rx_frame_o(rxf));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge mclk_i);
    psel <= 1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    pen <= 1;
    // sampled at the rising edge itself; only the bench timeout ends this wait
    do @(posedge mclk_i); while (pready !== 1'b1);
    r = prdata;
    e = perr;
    psel <= 0;
    pen <= 0;
  endtask

  function automatic logic hit(input int lay, input logic [31:0] w, input int s, input crff_frame_s f);
    logic [15:0] e;
    e = s[0] ? w[15:0] : w[31:16];
    case (lay)
      0: return w[31] == f.remote && w[30] == f.extended &&
           (f.extended ? w[28:0] == f.ident : w[28:18] == f.ident[28:18]);
      1: return e[15] == f.remote && e[14] == f.extended &&
           (f.extended ? e[13:0] == f.ident[28:15] : e[13:3] == f.ident[28:18]);
      2: return w[31-8*s -: 8] == f.ident[28:21];
      default: return 1'b0;
    endcase
  endfunction

  // frame aimed at one element, with one frame in four disturbed so misses occur too
  function automatic crff_frame_s mk(input int lay, input logic [31:0] w, input int s);
    crff_frame_s f;
    logic [15:0] e;
    f = 31'($urandom);
    e = s[0] ? w[15:0] : w[31:16];
    if (lay == 0) begin
      {f.remote, f.extended} = w[31:30];
      if (w[30]) f.ident = w[28:0];
      else f.ident[28:18] = w[28:18];
    end else if (lay == 1) begin
      {f.remote, f.extended} = e[15:14];
      if (e[14]) f.ident[28:15] = e[13:0];
      else f.ident[28:18] = e[13:3];
    end else f.ident[28:21] = w[31-8*s -: 8];
    if ($urandom % 4 == 0) f.ident[28] = ~f.ident[28];
    return f;
  endfunction

  task automatic frame(input int lay, input crff_frame_s f);
    int n, exp;
    n = (lay == 0) ? 1 : (lay == 1) ? 2 : 4;
    exp = -1;
    for (int i = 0; i < CRFF_TABLE_WORDS * n && exp < 0; i++)
      if (hit(lay, tbl[i / n], i % n, f)) exp = i;
    repeat ($urandom % 3) @(posedge mclk_i);
    @(posedge mclk_i);
    fr <= f;
    start <= 1;
    @(posedge mclk_i);
    start <= 0;
    n = 0;
    do begin @(negedge mclk_i); n++; end while (!(res.stored | res.rejected) && n < 300);
    check(res.stored, exp >= 0, "stored");
    check(res.rejected, exp < 0, "rejected");
    if (exp >= 0) check(res.element, exp, "element");
    if (exp >= 0) begin
      nsto++;
      lastel = exp;
    end else nrej++;
  endtask

  initial begin
    logic [31:0] r, d;
    logic        e;
    int          k;
    logic [11:0] bad [3];
    bad = '{12'h008, 12'h0e2, CRFF_TABLE_END + 12'h004};
    void'($urandom(56394));
    repeat (6) @(posedge mclk_i);
    rst_i <= 0;
    apb(0, CRFF_CTRL_OFF, 0, r, e);
    check(r, 0, "ctrl reset");
    foreach (bad[i]) begin
      apb(i[0], bad[i], $urandom, r, e);
      check(r, 0, "unmapped data");
      check(e, 1, "unmapped");
    end
    $display("map test done");
    for (int lay = 0; lay < 4; lay++) begin
      d = $urandom;
      d[9:8] = lay[1:0];
      apb(1, CRFF_CTRL_OFF, d, r, e);
      apb(0, CRFF_CTRL_OFF, 0, r, e);
      check(r, {22'h0, lay[1:0], 8'h00}, "layout");
      for (int i = 0; i < CRFF_TABLE_WORDS; i++) begin
        d = $urandom;
        if (lay == 0) d[29] = 1'b0;
        tbl[i] = d;
        apb(1, CRFF_TABLE_OFF + 12'(4 * i), d, r, e);
        check(e, 0, "table write");
      end
      k = $urandom % CRFF_TABLE_WORDS;
      apb(0, CRFF_TABLE_OFF + 12'(4 * k), 0, r, e);
      check(r, tbl[k], "table read");
      for (int j = 0; j < 8; j++) begin
        k = (j == 7) ? CRFF_TABLE_WORDS - 1 : $urandom % CRFF_TABLE_WORDS;
        frame(lay, mk(lay, tbl[k], $urandom % 4));
      end
      apb(0, CRFF_STAT_OFF, 0, r, e);
      check(r, {nsto[7:0], nrej[7:0], 7'h00, lastel[8:0]}, "status");
      $display("layout %0d done", lay);
    end
    tally_and_finish();
  end
endmodule
